// >>> period_match_timer_pkg.sv
// package: register map, field layout and reset values of the period match timer
package period_match_timer_pkg;
	localparam logic [3:0] addr_count_c = 4'h0;
	localparam logic [3:0] addr_period_c = 4'h4;
	localparam logic [3:0] addr_control_c = 4'h8;
	localparam logic [3:0] addr_status_c = 4'hC;
	localparam logic [3:0] addr_mask_c = 4'h0;
	localparam logic [4:0] addr_mask_full_c = 5'h10;
	localparam int ps_lo_c = 0;
	localparam int on_bit_c = 2;
	localparam int post_lo_c = 3;
	localparam logic [7:0] count_rst_c = 8'h00;
	localparam logic [7:0] period_rst_c = 8'hFF;
	localparam logic [6:0] control_rst_c = 7'h00;
	localparam logic [1:0] resp_okay_c = 2'h0;
	localparam logic [1:0] resp_slverr_c = 2'h2;
endpackage

// >>> period_match_timer_8bit.sv
// period match timer: 8-bit counter, prescaler, period compare, postscaler, axi4-lite slave
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// - while on, counter increments by one per prescaled tick from zero
// - prescale select bits 1:0: 00 divide 1, 01 divide 4, 1x divide 16
// - counter compared with period limit each cycle while on; equality gives match output
// - match clears counter next cycle and advances postscaler
// - software reads and writes counter and period limit at any time
// - reset clears counter and sets period limit to all ones
// - prescaler and postscaler cleared by counter write, control write, reset
// - control write leaves counter value unchanged
// - on bit 2 runs timer when set, stops it when clear
// - postscale bits 6:3 give code plus one matches per flag event
// - postscaler completion sets and latches the match interrupt flag
// - latched flag forwarded as interrupt only while enable bit set
// - unscaled match pulse provided as pwm time base
// - match output offered as spi shift clock source
// - control bit 7 unimplemented, reads zero
module period_match_timer_8bit #(
	parameter int count_width = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// timer outputs
	output logic match_pulse,
	output logic spi_shift_clock,
	output logic irq
);
	// the datapath is written for eight bits only, so refuse anything else at elaboration
	if (count_width != 8) begin : g_width_check
		$error("count_width must be 8");
	end

	logic [7:0] count_ff, nxt_count;
	logic [7:0] period_ff;
	logic [6:0] control_ff;
	logic [3:0] pre_ff, nxt_pre;
	logic [3:0] post_ff, nxt_post;
	logic flag_ff, nxt_flag;
	logic enable_ff;
	logic match_ff, shift_ff, irq_ff;
	logic aw_ff, w_ff, bvalid_ff, awready_ff, wready_ff;
	logic [4:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff;
	logic arready_ff, rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// one word per register from 0x00 to 0x10; anything else answers with an error
	function automatic logic is_mapped(input logic [4:0] a);
		return (a[1:0] == 2'h0) && (a[4:2] <= 3'h4);
	endfunction

	// write path: latch address and data separately, act when both held
	wire do_write = aw_ff && w_ff && !bvalid_ff;
	wire wr_lane0 = do_write && wstrb_ff[0];
	wire wr_count = wr_lane0 && (awaddr_ff == {1'b0, period_match_timer_pkg::addr_count_c});
	wire wr_period = wr_lane0 && (awaddr_ff == {1'b0, period_match_timer_pkg::addr_period_c});
	wire wr_control = wr_lane0 && (awaddr_ff == {1'b0, period_match_timer_pkg::addr_control_c});
	wire wr_mask = wr_lane0 && (awaddr_ff == period_match_timer_pkg::addr_mask_full_c);
	wire wr_mapped = is_mapped(awaddr_ff);

	// timer datapath
	wire timer_on = control_ff[period_match_timer_pkg::on_bit_c];
	wire [1:0] ps_sel = control_ff[period_match_timer_pkg::ps_lo_c +: 2];
	wire [3:0] post_sel = control_ff[period_match_timer_pkg::post_lo_c +: 4];
	wire [3:0] pre_last = ps_sel[1] ? 4'hF : (ps_sel[0] ? 4'h3 : 4'h0);
	wire tick = timer_on && (pre_ff == pre_last);
	// compare only while running, so a stopped timer raises no events
	wire match = timer_on && (count_ff == period_ff);
	wire post_done = match && (post_ff == post_sel);
	wire clear_scalers = wr_count || wr_control;

	// read path: reading status clears it, so a set in that cycle must survive
	wire rd_take = s_axi_arvalid && arready_ff;
	wire rd_status = rd_take && (s_axi_araddr == {1'b0, period_match_timer_pkg::addr_status_c});
	wire rd_mapped = is_mapped(s_axi_araddr);

	function automatic logic [31:0] read_mux(input logic [4:0] a);
		case (a)
			{1'b0, period_match_timer_pkg::addr_count_c}: read_mux = {24'h000000, count_ff};
			{1'b0, period_match_timer_pkg::addr_period_c}: read_mux = {24'h000000, period_ff};
			{1'b0, period_match_timer_pkg::addr_control_c}:
				read_mux = {25'h0, control_ff};
			{1'b0, period_match_timer_pkg::addr_status_c}: read_mux = {31'h0, flag_ff};
			period_match_timer_pkg::addr_mask_full_c: read_mux = {31'h0, enable_ff};
			default: read_mux = 32'h00000000;
		endcase
	endfunction

	always_comb begin
		nxt_pre = pre_ff;
		nxt_post = post_ff;
		nxt_count = count_ff;
		if (clear_scalers) begin
			nxt_pre = 4'h0;
		end else if (timer_on) begin
			nxt_pre = tick ? 4'h0 : pre_ff + 4'h1;
		end
		if (clear_scalers) begin
			nxt_post = 4'h0;
		end else if (match) begin
			nxt_post = post_done ? 4'h0 : post_ff + 4'h1;
		end
		if (wr_count) begin
			nxt_count = wdata_ff[7:0];
		end else if (match) begin
			nxt_count = period_match_timer_pkg::count_rst_c;
		end else if (tick) begin
			nxt_count = count_ff + 8'h01;
		end
		// control writes deliberately do not touch the count
		nxt_flag = flag_ff;
		if (rd_status) begin
			nxt_flag = 1'b0;
		end
		if (post_done) begin
			nxt_flag = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_ff <= period_match_timer_pkg::count_rst_c;
			period_ff <= period_match_timer_pkg::period_rst_c;
			control_ff <= period_match_timer_pkg::control_rst_c;
			pre_ff <= 4'h0;
			post_ff <= 4'h0;
			flag_ff <= 1'b0;
			enable_ff <= 1'b0;
			match_ff <= 1'b0;
			shift_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			pre_ff <= nxt_pre;
			post_ff <= nxt_post;
			flag_ff <= nxt_flag;
			if (wr_period) begin
				period_ff <= wdata_ff[7:0];
			end
			if (wr_control) begin
				control_ff <= wdata_ff[6:0];
			end
			if (wr_mask) begin
				enable_ff <= wdata_ff[0];
			end
			match_ff <= match;
			shift_ff <= match;
			irq_ff <= nxt_flag && enable_ff;
		end
	end

	// axi4-lite write channel handling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			awaddr_ff <= 5'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bresp_ff <= period_match_timer_pkg::resp_okay_c;
		end else begin
			awready_ff <= !aw_ff && !awready_ff && s_axi_awvalid;
			wready_ff <= !w_ff && !wready_ff && s_axi_wvalid;
			if (s_axi_awvalid && awready_ff) begin
				aw_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_ff) begin
				w_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_mapped ? period_match_timer_pkg::resp_okay_c
					: period_match_timer_pkg::resp_slverr_c;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
			end
		end
	end

	// axi4-lite read channel handling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= period_match_timer_pkg::resp_okay_c;
		end else begin
			arready_ff <= !arready_ff && !rvalid_ff && s_axi_arvalid;
			if (rd_take) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= read_mux(s_axi_araddr);
				rresp_ff <= rd_mapped ? period_match_timer_pkg::resp_okay_c
					: period_match_timer_pkg::resp_slverr_c;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign match_pulse = match_ff;
	assign spi_shift_clock = shift_ff;
	assign irq = irq_ff;

	property p_count_inc;
		@(posedge aclk) disable iff (!aresetn)
		(tick && !match && !wr_count) |=> (count_ff == $past(count_ff) + 8'h01);
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("count did not increment");

	property p_div4;
		@(posedge aclk) disable iff (!aresetn)
		(timer_on && ps_sel == 2'h1 && tick && !clear_scalers)[*1] ##1
		(timer_on && ps_sel == 2'h1 && !clear_scalers)[*3] |-> !tick;
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four ticked early");

	property p_match_out;
		@(posedge aclk) disable iff (!aresetn)
		(timer_on && count_ff == period_ff) |=> match_pulse;
	endproperty
	a_match_out: assert property (p_match_out) else $error("match output missing");

	property p_match_clear;
		@(posedge aclk) disable iff (!aresetn)
		(match && !wr_count) |=> (count_ff == 8'h00);
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("count not cleared on match");

	property p_reset_vals;
		@(posedge aclk) $rose(aresetn) |-> (count_ff == 8'h00 && period_ff == 8'hFF);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_scaler_clear;
		@(posedge aclk) disable iff (!aresetn)
		clear_scalers |=> (pre_ff == 4'h0 && post_ff == 4'h0);
	endproperty
	a_scaler_clear: assert property (p_scaler_clear) else $error("scalers not cleared");

	property p_ctrl_keep;
		@(posedge aclk) disable iff (!aresetn)
		(wr_control && !match && !tick) |=> (count_ff == $past(count_ff));
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("control write moved count");

	property p_off_hold;
		@(posedge aclk) disable iff (!aresetn)
		(!timer_on && !wr_count) |=> (count_ff == $past(count_ff) && !match_pulse);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("stopped timer moved");

	property p_flag_set;
		@(posedge aclk) disable iff (!aresetn)
		post_done |=> flag_ff;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not latched");

	property p_irq_gate;
		@(posedge aclk) disable iff (!aresetn)
		irq |-> $past(enable_ff);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

	property p_count_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_count |=> (count_ff == $past(wdata_ff[7:0]));
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost");

	property p_period_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_period |=> (period_ff == $past(wdata_ff[7:0]));
	endproperty
	a_period_write: assert property (p_period_write) else $error("period write lost");

	property p_div1;
		@(posedge aclk) disable iff (!aresetn)
		(timer_on && ps_sel == 2'h0) |-> tick;
	endproperty
	a_div1: assert property (p_div1) else $error("divide by one missed a tick");

	property p_div16;
		@(posedge aclk) disable iff (!aresetn)
		(timer_on && ps_sel[1] && tick && !clear_scalers) ##1
		(timer_on && ps_sel[1] && !clear_scalers)[*8] |-> !tick;
	endproperty
	a_div16: assert property (p_div16) else $error("divide by sixteen ticked early");

	property p_on_bit;
		@(posedge aclk) disable iff (!aresetn)
		wr_control |=> (timer_on == $past(wdata_ff[period_match_timer_pkg::on_bit_c]));
	endproperty
	a_on_bit: assert property (p_on_bit) else $error("on bit not taken");

	property p_post_range;
		@(posedge aclk) disable iff (!aresetn)
		post_ff <= post_sel;
	endproperty
	a_post_range: assert property (p_post_range) else $error("postscaler past its count");

	property p_flag_early;
		@(posedge aclk) disable iff (!aresetn)
		(!post_done && !flag_ff) |=> !flag_ff;
	endproperty
	a_flag_early: assert property (p_flag_early) else $error("flag set before count done");

	property p_flag_hold;
		@(posedge aclk) disable iff (!aresetn)
		(flag_ff && !rd_status) |=> flag_ff;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a read");

	property p_irq_level;
		@(posedge aclk) disable iff (!aresetn)
		(flag_ff && enable_ff && !rd_status) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("enabled flag gave no irq");

	property p_base_clear;
		@(posedge aclk) disable iff (!aresetn)
		match_pulse |-> (count_ff == 8'h00 || $past(wr_count));
	endproperty
	a_base_clear: assert property (p_base_clear) else $error("time base pulse off period");

	property p_shift_same;
		@(posedge aclk) disable iff (!aresetn)
		spi_shift_clock == match_pulse;
	endproperty
	a_shift_same: assert property (p_shift_same) else $error("shift clock differs");

	property p_ctrl_read;
		@(posedge aclk) disable iff (!aresetn)
		(rd_take && s_axi_araddr == {1'b0, period_match_timer_pkg::addr_control_c})
			|=> (s_axi_rdata[31:7] == 25'h0);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control bit 7 read set");

	property p_off_flag;
		@(posedge aclk) disable iff (!aresetn)
		(!timer_on && !flag_ff) |=> !flag_ff;
	endproperty
	a_off_flag: assert property (p_off_flag) else $error("stopped timer set flag");
endmodule // period_match_timer_8bit

// >>> period_match_timer_8bit_tb_top.sv
// testbench of the period match timer: axi register access, counting, match and interrupt
`timescale 1ns/1ps
module period_match_timer_8bit_tb_top;
	localparam logic [4:0] a_cnt = {1'b0, period_match_timer_pkg::addr_count_c};
	localparam logic [4:0] a_per = {1'b0, period_match_timer_pkg::addr_period_c};
	localparam logic [4:0] a_ctl = {1'b0, period_match_timer_pkg::addr_control_c};
	localparam logic [4:0] a_sts = {1'b0, period_match_timer_pkg::addr_status_c};
	localparam logic [4:0] a_msk = period_match_timer_pkg::addr_mask_full_c;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, match_pulse, spi_shift_clock, irq;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, seed;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, bres, rres;
	logic [7:0] per;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int n, gap, k;

	period_match_timer_8bit #(.count_width(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.match_pulse(match_pulse), .spi_shift_clock(spi_shift_clock), .irq(irq));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// a hung handshake or a timer that never matches ends here
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			complete_run;
		end
	end

	task complete_run;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function int exp_div(input int code);
		return (code == 0) ? 1 : ((code == 1) ? 4 : 16);
	endfunction

	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bres = bresp;
		bready <= 1'b0;
	endtask

	task rd_reg(input logic [4:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rres = rresp;
		rready <= 1'b0;
	endtask

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		seed = 32'h8308;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(a_cnt); chk(rd, 32'h00);
		rd_reg(a_per); chk(rd, 32'hFF);
		rd_reg(a_ctl); chk(rd, 32'h00);
		wr(a_ctl, 8'hFF); chk({30'h0, bres}, 32'h0);
		rd_reg(a_ctl); chk(rd, 32'h7F);
		wr(a_ctl, 8'h00);
		rd_reg(5'h14); chk({30'h0, rres}, 32'h2);
		$display("test registers done");
		// fixed window per prescale code; the window is a few cycles longer than 64
		for (int c = 0; c < 4; c++) begin
			wr(a_cnt, 8'h00);
			wr(a_ctl, {5'h00, 1'b1, c[1:0]});
			repeat (64) @(posedge aclk);
			wr(a_ctl, {5'h00, 1'b0, c[1:0]});
			rd_reg(a_cnt);
			n = rd;
			chk(32'((n >= 64 / exp_div(c)) && (n <= 80 / exp_div(c) + 1)), 32'h1);
			repeat (20) @(posedge aclk);
			rd_reg(a_cnt); chk(rd, n);
		end
		$display("test prescale done");
		for (int t = 0; t < 3; t++) begin
			seed = lfsr(seed);
			per = 8'h02 + {5'h0, seed[2:0]};
			k = (t == 0) ? 0 : ((t == 1) ? 15 : int'(seed[6:3]));
			wr(a_ctl, 8'h00);
			wr(a_per, per);
			rd_reg(a_per); chk(rd, {24'h0, per});
			wr(a_msk, 8'h01);
			rd_reg(a_sts);
			wr(a_cnt, 8'h00);
			wr(a_ctl, {1'b0, k[3:0], 1'b1, 2'b00});
			n = 0;
			gap = 0;
			do begin
				@(posedge aclk);
				gap++;
				chk({31'h0, spi_shift_clock}, {31'h0, match_pulse});
				if (match_pulse === 1'b1) begin
					if (n > 0) chk(gap, per + 1);
					n++;
					gap = 0;
				end
			end while (irq !== 1'b1);
			chk(n, k + 1);
			wr(a_ctl, 8'h00);
			wr(a_msk, 8'h00);
			@(posedge aclk); chk({31'h0, irq}, 32'h0);
			wr(a_msk, 8'h01);
			@(posedge aclk); chk({31'h0, irq}, 32'h1);
			rd_reg(a_sts); chk(rd, 32'h1);
			@(posedge aclk); chk({31'h0, irq}, 32'h0);
		end
		$display("test match and postscale done");
		// a reset in mid-run must bring back power-up values over written ones
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(a_per); chk(rd, 32'hFF);
		rd_reg(a_cnt); chk(rd, 32'h00);
		$display("test reset done");
		complete_run;
	end
endmodule // period_match_timer_8bit_tb_top
